/* core/dbgtc_top.v */
// Debug trigger and trace controller with AXI4-Lite registers and breakpoint requests
//
// The address map and the AXI4-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
`include "dbgtc_consts.vh"
module dbgtc_top
(
  input wire aclk,
  input wire aresetn,
  input wire clk_en,
  input wire [3:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [3:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cmp_a_match,
  input wire cmp_b_match,
  input wire bus_rw,
  input wire [7:0] bus_data,
  input wire fetch_tag_load,
  input wire exec_start,
  input wire instr_done,
  input wire cof_valid,
  input wire [15:0] cof_addr,
  output reg brk_tag_req,
  output reg background_entry_opcode_req,
  output reg irq
);
  reg [7:0] ctrl;
  reg [7:0] trig;
  reg run_active_flag;
  reg af;
  reg bf;
  reg [3:0] cnt;
  reg [15:0] fifo_mem [0:7];
  reg [2:0] wr_ptr;
  reg [2:0] rd_ptr;
  reg a_seen;
  reg capturing;
  reg force_pend;
  reg [1:0] irq_stat;
  reg [1:0] irq_en;
  reg [3:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  // Each tracker is a tag pipeline one entry per queue slot
  reg [1:0] trk_a;
  reg [1:0] trk_b;

  function [7:0] dbgtc_merge;
    input [7:0] old;
    input [31:0] data;
    input [3:0] strb;
    begin
      dbgtc_merge = strb[0] ? data[7:0] : old;
    end
  endfunction

  function dbgtc_rwq;
    input match;
    input qen;
    input qval;
    input rw;
    begin
      dbgtc_rwq = match && (!qen || (qval == rw));
    end
  endfunction

  function ta_load;
    input m;
    begin
      ta_load = m && fetch_tag_load;
    end
  endfunction

  wire [3:0] mode = trig[3:0];
  wire src_tag = trig[`DBGTC_TRIG_SRC];
  wire evt_only = (mode == `DBGTC_MODE_EVT_B) || (mode == `DBGTC_MODE_A_THEN_EVT_B);
  wire begin_sel = trig[`DBGTC_TRIG_BEGIN] || evt_only;
  wire qa = dbgtc_rwq(cmp_a_match, ctrl[`DBGTC_CTRL_RW_QUAL_A_ENABLE], ctrl[`DBGTC_CTRL_RWA], bus_rw);
  wire qb = dbgtc_rwq(cmp_b_match, ctrl[`DBGTC_CTRL_RW_QUAL_B_ENABLE], ctrl[`DBGTC_CTRL_RWB], bus_rw);
  // Tag mode takes the match only when the tagged opcode reaches execution
  wire ta = src_tag ? (exec_start && trk_a[1]) : qa;
  wire tb = src_tag ? (exec_start && trk_b[1]) : qb;
  reg trig_hit;
  always @*
  begin
    case (mode)
      `DBGTC_MODE_A_ONLY: trig_hit = ta;
      `DBGTC_MODE_A_OR_B: trig_hit = ta || tb;
      `DBGTC_MODE_A_THEN_B: trig_hit = a_seen && tb;
      `DBGTC_MODE_EVT_B: trig_hit = tb;
      `DBGTC_MODE_A_THEN_EVT_B: trig_hit = a_seen && tb;
      `DBGTC_MODE_A_AND_B: trig_hit = ta && tb;
      `DBGTC_MODE_A_NOT_B: trig_hit = ta && !tb;
      `DBGTC_MODE_INSIDE: trig_hit = ta && tb;
      `DBGTC_MODE_OUTSIDE: trig_hit = ta ^ tb;
      default: trig_hit = 1'b0;
    endcase
  end

  wire fifo_full = (cnt == 4'h8);
  wire evt_store = evt_only && tb;
  wire store_ok = evt_only ? evt_store : cof_valid;
  wire [15:0] store_word = evt_only ? {8'h00, bus_data} : cof_addr;
  wire do_store = run_active_flag && store_ok && (begin_sel ? (capturing || trig_hit) : 1'b1);
  wire fire = run_active_flag && trig_hit;
  wire brk_on = ctrl[`DBGTC_CTRL_BREAKPOINT_REQUEST_ENABLE] && run_active_flag;
  wire wr_go = aw_have && w_have && !s_axi_bvalid;
  wire wr_ctrl = wr_go && (aw_addr == `DBGTC_OFF_CTRL) && w_strb[0];
  wire wr_trig = wr_go && (aw_addr == `DBGTC_OFF_TRIG) && w_strb[0];
  wire wr_irq = wr_go && (aw_addr == `DBGTC_OFF_STAT) && w_strb[0];
  wire [7:0] next_ctrl = dbgtc_merge(ctrl, w_data, w_strb);
  wire arm_write = wr_ctrl && next_ctrl[`DBGTC_CTRL_ARM] && next_ctrl[`DBGTC_CTRL_EN];
  wire stop_write = wr_ctrl && !(next_ctrl[`DBGTC_CTRL_ARM] && next_ctrl[`DBGTC_CTRL_EN]);
  wire rd_fifo = s_axi_arvalid && s_axi_arready && (s_axi_araddr == `DBGTC_OFF_FIFO);
  wire pop = rd_fifo && !run_active_flag && (cnt != 4'h0);
  wire run_end = begin_sel ? (do_store && cnt == 4'h7) : fire;

  wire [31:0] stat_word = {
    14'h0000,
    irq_en,
    6'h00,
    irq_stat,
    run_active_flag,
    af,
    bf,
    1'b0,
    cnt
  };

  // Queue trackers: a fetch shifts in the qualified match, execution examines slot 1
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      trk_a <= 2'h0;
      trk_b <= 2'h0;
    end
    else if (clk_en)
    begin
      // Only fetches move the queue, so a tag stays aligned with its own opcode
      if (fetch_tag_load)
      begin
        trk_a <= {trk_a[0], ta_load(qa)};
        trk_b <= {trk_b[0], ta_load(qb)};
      end
    end
  end

  // Configuration registers
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl <= 8'h00;
      trig <= 8'h00;
      irq_en <= 2'h0;
    end
    else if (clk_en)
    begin
      if (wr_trig)
        trig <= dbgtc_merge(trig, w_data, w_strb);
      if (wr_ctrl)
        ctrl <= next_ctrl;
      if (wr_go && aw_addr == `DBGTC_OFF_STAT && w_strb[1])
        irq_en <= w_data[9:8];
    end
  end

  // Run control, hit flags and capture FIFO
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      run_active_flag <= 1'b0;
      af <= 1'b0;
      bf <= 1'b0;
      a_seen <= 1'b0;
      capturing <= 1'b0;
      cnt <= 4'h0;
      wr_ptr <= 3'h0;
      rd_ptr <= 3'h0;
    end
    else if (clk_en)
    begin
      if (run_active_flag && ta)
      begin
        af <= 1'b1;
        a_seen <= 1'b1;
      end
      if (run_active_flag && tb)
        bf <= 1'b1;
      if (fire)
        capturing <= 1'b1;
      // A full circular FIFO drops its oldest word to keep the newest
      if (do_store)
      begin
        fifo_mem[wr_ptr] <= store_word;
        wr_ptr <= wr_ptr + 3'h1;
        if (!fifo_full)
          cnt <= cnt + 4'h1;
        else
          rd_ptr <= rd_ptr + 3'h1;
      end
      else if (pop)
      begin
        rd_ptr <= rd_ptr + 3'h1;
        cnt <= cnt - 4'h1;
      end
      if (run_active_flag && run_end)
        run_active_flag <= 1'b0;
      if (stop_write)
        run_active_flag <= 1'b0;
      if (arm_write)
      begin
        run_active_flag <= 1'b1;
        af <= 1'b0;
        bf <= 1'b0;
        cnt <= 4'h0;
        wr_ptr <= 3'h0;
        rd_ptr <= 3'h0;
        a_seen <= 1'b0;
        capturing <= 1'b0;
      end
    end
  end

  // Breakpoint requests towards the CPU
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      force_pend <= 1'b0;
      brk_tag_req <= 1'b0;
      background_entry_opcode_req <= 1'b0;
    end
    else if (clk_en)
    begin
      // Tag request is registered one cycle after the trigger fires, not tied to a fetch; force waits for instruction end
      brk_tag_req <= brk_on && ctrl[`DBGTC_CTRL_TAG] && fire;
      if (brk_on && !ctrl[`DBGTC_CTRL_TAG] && fire)
        force_pend <= 1'b1;
      else if (instr_done)
        force_pend <= 1'b0;
      background_entry_opcode_req <= (force_pend && instr_done) ||
        (exec_start && brk_on && ctrl[`DBGTC_CTRL_TAG] && src_tag && trig_hit);
    end
  end

  // Interrupt status and level output
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      irq_stat <= 2'h0;
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      // Set wins over software clear
      irq_stat <= (irq_stat & ~(wr_irq ? w_data[1:0] : 2'h0)) |
        {fire, run_active_flag && run_end};
      irq <= |(irq_stat & irq_en);
    end
  end

  // Write address, write data and write response channels
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 4'h0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end
    else if (clk_en)
    begin
      s_axi_awready <= !aw_have && !s_axi_awready;
      s_axi_wready <= !w_have && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_have <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_have <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_addr[1:0] == 2'h0 && aw_addr != `DBGTC_OFF_FIFO) ?
          `DBGTC_RESP_OKAY : `DBGTC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // Read address and read data channels
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end
    else if (clk_en)
    begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `DBGTC_RESP_OKAY;
        case (s_axi_araddr)
          `DBGTC_OFF_CTRL: s_axi_rdata <= {24'h000000, ctrl};
          `DBGTC_OFF_TRIG: s_axi_rdata <= {24'h000000, trig};
          `DBGTC_OFF_STAT: s_axi_rdata <= stat_word;
          `DBGTC_OFF_FIFO: s_axi_rdata <= {16'h0000, fifo_mem[rd_ptr]};
          default:
          begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DBGTC_RESP_SLVERR;
          end
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

/* shared/dbgtc_consts.vh */
// Register map, field positions and encodings of the debug trigger and trace controller
`ifndef DBGTC_CONSTS_VH
`define DBGTC_CONSTS_VH
`define DBGTC_OFF_CTRL 4'h0
`define DBGTC_OFF_TRIG 4'h4
`define DBGTC_OFF_STAT 4'h8
`define DBGTC_OFF_FIFO 4'hc
`define DBGTC_CTRL_EN 0
`define DBGTC_CTRL_ARM 1
`define DBGTC_CTRL_BREAKPOINT_REQUEST_ENABLE 2
`define DBGTC_CTRL_TAG 3
`define DBGTC_CTRL_RW_QUAL_A_ENABLE 4
`define DBGTC_CTRL_RWA 5
`define DBGTC_CTRL_RW_QUAL_B_ENABLE 6
`define DBGTC_CTRL_RWB 7
`define DBGTC_TRIG_MODE_LO 0
`define DBGTC_TRIG_BEGIN 6
`define DBGTC_TRIG_SRC 7
`define DBGTC_STAT_CNT_LO 0
`define DBGTC_STAT_BF 5
`define DBGTC_STAT_AF 6
`define DBGTC_STAT_RUN_ACTIVE_FLAG 7
`define DBGTC_MODE_A_ONLY 4'h0
`define DBGTC_MODE_A_OR_B 4'h1
`define DBGTC_MODE_A_THEN_B 4'h2
`define DBGTC_MODE_EVT_B 4'h3
`define DBGTC_MODE_A_THEN_EVT_B 4'h4
`define DBGTC_MODE_A_AND_B 4'h5
`define DBGTC_MODE_A_NOT_B 4'h6
`define DBGTC_MODE_INSIDE 4'h7
`define DBGTC_MODE_OUTSIDE 4'h8
`define DBGTC_FIFO_DEPTH 8
`define DBGTC_CNT_W 4
`define DBGTC_RESP_OKAY 2'h0
`define DBGTC_RESP_SLVERR 2'h2
`endif

/* verification/dbgtc_cpu_model.sv */
// Instruction queue partner pacing fetch, execute and completion
`timescale 1ns/1ns
`default_nettype none
module dbgtc_cpu_model
(
  input wire logic aclk,
  input wire logic aresetn,
  output var logic fetch_tag_load,
  output var logic exec_start,
  output var logic instr_done,
  output var logic [15:0] cof_addr
);
  logic [1:0] ph;
  always @(posedge aclk)
  begin
    ph <= aresetn ? ph + 2'h1 : 2'h0;
    cof_addr <= aresetn ? cof_addr + {14'h0, instr_done, 1'b0} : 16'h1000;
  end
  // One opcode per four cycles keeps fetch, execute and completion apart
  assign fetch_tag_load = aresetn && ph == 2'h0;
  assign exec_start = aresetn && ph == 2'h1;
  assign instr_done = aresetn && ph == 2'h3;
endmodule
`default_nettype wire

/* verification/dbgtc_monitor.sv */
// Bus handshake and breakpoint timing checker for the debug trigger controller
`timescale 1ns/1ns
`default_nettype none
module dbgtc_monitor
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic exec_start,
  input wire logic instr_done,
  input wire logic background_entry_opcode_req,
  input wire logic brk_tag_req
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) else $error("b drop");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid) else $error("r drop");
  ar_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("r late");
  w_answer_a: assert property (s_axi_wvalid && s_axi_wready |-> ##[1:4] s_axi_bvalid)
    else $error("b late");
  aw_pulse_a: assert property (s_axi_awready |=> !s_axi_awready) else $error("aw pulse");
  ar_pulse_a: assert property (s_axi_arready |=> !s_axi_arready) else $error("ar pulse");
  background_entry_opcode_cause_a: assert property (background_entry_opcode_req |-> $past(instr_done) || $past(exec_start))
    else $error("background_entry_opcode cause");
  background_entry_opcode_pulse_a: assert property (background_entry_opcode_req |=> !background_entry_opcode_req) else $error("background_entry_opcode pulse");
  cover property (background_entry_opcode_req);
  cover property (brk_tag_req);
  cover property (s_axi_rvalid && s_axi_rready);
endmodule
bind dbgtc_top dbgtc_monitor i_mon
(
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .exec_start(exec_start), .instr_done(instr_done),
  .background_entry_opcode_req(background_entry_opcode_req), .brk_tag_req(brk_tag_req)
);
`default_nettype wire

/* verification/tb_debug_trigger_trace_control.sv */
// Self-checking bench for the debug trigger and trace controller
`timescale 1ns/1ns
`default_nettype none
`include "dbgtc_consts.vh"
module tb_debug_trigger_trace_control;
  logic clk = 0, rn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0, ca = 0, cb = 0, rw = 0;
  logic fix = 0, awr, wrd, bv, arr, rv, ftl, exs, idn, tg, bg, irq, b0;
  logic [3:0] awa = 0, ara = 0, ws = 0;
  logic [31:0] wd = 0, rd;
  logic [7:0] bd = 0;
  logic [15:0] cfa;
  logic [1:0] br, rr;
  logic [63:0] e, rq[$];
  logic [1:0] bq[$];
  integer n_fail = 0, check_count = 0, seed = 32'h7769, nb = 0, nt = 0, m;
  always #4 clk = ~clk;
  dbgtc_top i_dut
  (
    .aclk(clk), .aresetn(rn), .clk_en(1'b1), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .cmp_a_match(ca), .cmp_b_match(cb),
    .bus_rw(rw), .bus_data(bd), .fetch_tag_load(ftl), .exec_start(exs), .instr_done(idn),
    .cof_valid(idn), .cof_addr(cfa), .brk_tag_req(tg), .background_entry_opcode_req(bg), .irq(irq)
  );
  dbgtc_cpu_model i_cpu
  (
    .aclk(clk), .aresetn(rn), .fetch_tag_load(ftl), .exec_start(exs), .instr_done(idn),
    .cof_addr(cfa)
  );
  task automatic chk(input logic ok, input string s);
  begin
    check_count++;
    if (ok !== 1'b1)
    begin
      n_fail++;
      $display("mismatch at %0t: %s", $time, s);
    end
  end
  endtask
  task automatic axw(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] r);
  begin
    bq.push_back(r);
    awa <= a;
    wd <= d;
    ws <= s;
    awv <= 1;
    wv <= 1;
    bry <= 1;
    do
    begin
      @(posedge clk);
      if (awr) awv <= 0;
      if (wrd) wv <= 0;
    end
    while (!bv);
    bry <= 0;
    @(posedge clk);
  end
  endtask
  task automatic axr(input logic [3:0] a, input logic [31:0] x, input logic [31:0] k);
  begin
    rq.push_back({k, x});
    ara <= a;
    arv <= 1;
    rry <= 1;
    do
    begin
      @(posedge clk);
      if (arr) arv <= 0;
    end
    while (!rv);
    rry <= 0;
    @(posedge clk);
  end
  endtask
  task automatic hit(input logic a, input logic b, input integer n);
  begin
    ca <= a;
    cb <= b;
    repeat (n) @(posedge clk);
    ca <= 0;
    cb <= 0;
    @(posedge clk);
  end
  endtask
  task automatic bp(input logic [31:0] c, input logic eb, input logic et);
    integer b, t;
  begin
    b = nb;
    t = nt;
    axw(`DBGTC_OFF_CTRL, c, 4'h1, `DBGTC_RESP_OKAY);
    hit(1, 0, 4);
    repeat (16) @(posedge clk);
    chk((nb != b) === eb, "background entry");
    chk((nt != t) === et, "tag request");
  end
  endtask
  always @(posedge clk)
  begin
    bd <= $random(seed);
    rw <= fix ? 1'b0 : $random(seed);
    nb <= nb + bg;
    nt <= nt + tg;
    if (rv && rry)
    begin
      e = rq.pop_front();
      chk((rd & e[63:32]) === e[31:0], "read data");
    end
    if (bv && bry) chk(br === bq.pop_front(), "write response");
  end
  task tally_and_finish;
  begin
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  initial
  begin
    #300000;
    n_fail++;
    tally_and_finish;
  end
  initial
  begin
    repeat (3) @(posedge clk);
    rn <= 1;
    @(posedge clk);
    axr(`DBGTC_OFF_CTRL, 0, 32'hff);
    axw(`DBGTC_OFF_FIFO, 0, 4'h1, `DBGTC_RESP_SLVERR);
    axw(`DBGTC_OFF_STAT, 32'h100, 4'h2, `DBGTC_RESP_OKAY);
    for (m = 0; m < 16; m++)
    begin
      axw(`DBGTC_OFF_TRIG, m, 4'h1, `DBGTC_RESP_OKAY);
      axw(`DBGTC_OFF_CTRL, 3, 4'h1, `DBGTC_RESP_OKAY);
      axr(`DBGTC_OFF_STAT, 32'h80, 32'hf0);
      hit(1, 0, 1);
      hit(0, 1, 1);
      hit(1, 1, 1);
      b0 = m == 3 || m == 4 || m > 8;
      axr(`DBGTC_OFF_STAT, {b0, 7'h0}, 32'h80);
      chk(irq === !b0, "run end interrupt");
      axw(`DBGTC_OFF_CTRL, 1, 4'h1, `DBGTC_RESP_OKAY);
      axr(`DBGTC_OFF_STAT, 0, 32'h80);
      axw(`DBGTC_OFF_STAT, 3, 4'h1, `DBGTC_RESP_OKAY);
      chk(irq === 1'b0, "interrupt clear");
      $display("mode %0d done", m);
    end
    axw(`DBGTC_OFF_TRIG, 32'h40, 4'h1, `DBGTC_RESP_OKAY);
    axw(`DBGTC_OFF_CTRL, 3, 4'h1, `DBGTC_RESP_OKAY);
    hit(1, 0, 1);
    for (m = 0; m < 200 && irq !== 1'b1; m++) @(posedge clk);
    axr(`DBGTC_OFF_STAT, 32'h08, 32'h8f);
    $display("begin trace done");
    bp(32'h07, 1, 0);
    axw(`DBGTC_OFF_TRIG, 32'hc0, 4'h1, `DBGTC_RESP_OKAY);
    bp(32'h0f, 1, 1);
    axw(`DBGTC_OFF_TRIG, 32'h40, 4'h1, `DBGTC_RESP_OKAY);
    fix <= 1;
    bp(32'h37, 0, 0);
    bp(32'h17, 1, 0);
    $display("breakpoints done");
    tally_and_finish;
  end
endmodule
`default_nettype wire
